// file: pkg/dsc_if.sv
`timescale 1ns/1ps
interface dsc_if;
  logic cs_n;
  logic sclk;
  logic sdi;
  logic sdo;
  logic dac_load_strobe_n;

  modport host
  (
    output cs_n,
    output sclk,
    output sdi,
    output dac_load_strobe_n,
    input  sdo
  );

  modport dev
  (
    input  cs_n,
    input  sclk,
    input  sdi,
    input  dac_load_strobe_n,
    output sdo
  );
endinterface

// file: pkg/dsc_pkg.sv
package dsc_pkg;
  // Serial word layout
  localparam int WORD_BITS    = 16;
  localparam int CHAN_MSB     = 13;
  localparam int CHAN_LSB     = 11;
  localparam int PHASE_BIT    = 13;
  localparam int CODE_MSB     = 10;
  localparam int CODE_LSB     = 8;
  localparam int DATA_MSB     = 7;
  localparam int DATA_LSB     = 0;
  localparam int NUM_CHAN     = 8;
  localparam int CHAN_BITS    = 8;

  // Command codes
  localparam logic [2:0] CODE_NOP        = 3'h0;
  localparam logic [2:0] CODE_CLEAR      = 3'h1;
  localparam logic [2:0] CODE_SHUTDOWN   = 3'h2;
  localparam logic [2:0] CODE_PHASE_LOAD = 3'h3;
  localparam logic [2:0] CODE_LOAD_ALL   = 3'h4;
  localparam logic [2:0] CODE_LOAD_INPUT = 3'h5;
  localparam logic [2:0] CODE_LOAD_BOTH  = 3'h6;
  localparam logic [2:0] CODE_SW_LOAD    = 3'h7;

  // Reset values
  localparam logic       PHASE_RST = 1'b0;
  localparam logic [7:0] CODE_RST  = 8'h00;
  localparam logic [7:0] POWER_RST = 8'hff;
  localparam logic       SDO_RST   = 1'b0;

  // Timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int SCLK_HALF_NS  = 150;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Host word buffer
  localparam int FIFO_DEPTH = 4;
endpackage

// file: rtl/dsc_dev.sv
`timescale 1ns/1ps
// Behaviour
// - Software load copies inputs on select rise
// - Load pin low makes DAC registers transparent
// - Output follows shift register, edge per mode
// - Falling mode lag is 16.5 clocks
// - Rising mode lag is 16 clocks
// - Power-up output edge is falling
// - Serial output always driven
// - Output holds while select high
// - Master uses polarity and phase zero
// - Polarity and phase one ignores output
// - Master idles serial clock low
// - Clock toggles only during updates
// - Chain output to input, all falling mode
// - No-op passes data, changes nothing
// - Chain executes together on select rise
// - Code 111 is software load
// - Code 000 is no-op
// - Code 011 sets edge and loads
// - Rising edge mode stays until changed
module dsc_dev (
  input  wire logic            clk_i,
  input  wire logic            rst_i,
  dsc_if.dev                   bus,
  output logic [7:0][7:0]      dac_code_o,
  output logic [7:0]           dac_update_o,
  output logic [7:0]           buffer_on_o,
  output logic                 sdo_rising_o,
  output logic [2:0]           command_code_o,
  output logic                 command_strobe_o,
  output logic                 frame_short_o
);
  localparam int NCH = dsc_pkg::NUM_CHAN;
  localparam int CB  = dsc_pkg::CHAN_BITS;

  typedef struct packed {
    logic [1:0]               cs_sy;
    logic [1:0]               sck_sy;
    logic [1:0]               sdi_sy;
    logic [1:0]               ld_sy;
    logic                     cs_d;
    logic                     sck_d;
    logic [15:0]              sh;
    logic [4:0]               nbits;
    logic                     stage;
    logic                     sdo;
    logic                     phase;
    logic [NCH-1:0][CB-1:0]   inreg;
    logic [NCH-1:0][CB-1:0]   dacreg;
    logic [NCH-1:0]           power;
    logic [NCH-1:0]           upd;
    logic [2:0]               code;
    logic                     strobe;
    logic                     short_f;
  } dsc_dev_s;

  dsc_dev_s s_r;
  dsc_dev_s s_nxt;

  function automatic logic [NCH-1:0] chan_hot(input logic [2:0] sel);
    chan_hot      = '0;
    chan_hot[sel] = 1'b1;
  endfunction

  always_comb
  begin
    logic             cs;
    logic             sck;
    logic             rise;
    logic             fall;
    logic             cs_rise;
    logic [2:0]       code;
    logic [2:0]       chan;
    logic [CB-1:0]    data;
    logic [NCH-1:0]   hot;
    cs      = 1'b1;
    sck     = 1'b0;
    rise    = 1'b0;
    fall    = 1'b0;
    cs_rise = 1'b0;
    code    = '0;
    chan    = '0;
    data    = '0;
    hot     = '0;
    s_nxt   = s_r;

    // Pins come from the host's domain: two stages before use
    s_nxt.cs_sy  = {s_r.cs_sy[0], bus.cs_n};
    s_nxt.sck_sy = {s_r.sck_sy[0], bus.sclk};
    s_nxt.sdi_sy = {s_r.sdi_sy[0], bus.sdi};
    s_nxt.ld_sy  = {s_r.ld_sy[0], bus.dac_load_strobe_n};
    cs           = s_r.cs_sy[1];
    sck          = s_r.sck_sy[1];
    s_nxt.cs_d   = cs;
    s_nxt.sck_d  = sck;
    // Edges only count while selected, so the output freezes otherwise
    rise         = sck & ~s_r.sck_d & ~cs;
    fall         = ~sck & s_r.sck_d & ~cs;
    cs_rise      = cs & ~s_r.cs_d;
    s_nxt.strobe = 1'b0;
    s_nxt.short_f = 1'b0;

    if (~cs & s_r.cs_d)
      s_nxt.nbits = '0;

    if (rise)
    begin
      s_nxt.sh    = {s_r.sh[14:0], s_r.sdi_sy[1]};
      s_nxt.stage = s_r.sh[15];
      if (s_r.nbits != 5'h10)
        s_nxt.nbits = s_r.nbits + 1'b1;
      if (s_r.phase)
        s_nxt.sdo = s_r.sh[15];
    end
    // Stage register adds the extra half clock
    if (fall && !s_r.phase)
      s_nxt.sdo = s_r.stage;

    code = s_r.sh[dsc_pkg::CODE_MSB:dsc_pkg::CODE_LSB];
    chan = s_r.sh[dsc_pkg::CHAN_MSB:dsc_pkg::CHAN_LSB];
    data = s_r.sh[dsc_pkg::DATA_MSB:dsc_pkg::DATA_LSB];
    hot  = chan_hot(chan);

    if (cs_rise && s_r.nbits != 5'h10)
      s_nxt.short_f = 1'b1;
    // Frames of at least 16 bits execute; a short frame holds no command
    if (cs_rise && s_r.nbits == 5'h10)
    begin
      s_nxt.code   = code;
      s_nxt.strobe = 1'b1;
      case (code)
        dsc_pkg::CODE_NOP:
        begin
          // Nothing stored; the word simply passed through
          s_nxt.code = code;
        end
        dsc_pkg::CODE_CLEAR:
        begin
          s_nxt.inreg  = '0;
          s_nxt.dacreg = '0;
          s_nxt.power  = dsc_pkg::POWER_RST;
        end
        dsc_pkg::CODE_SHUTDOWN:
        begin
          s_nxt.power = data;
        end
        dsc_pkg::CODE_PHASE_LOAD:
        begin
          // Edge choice stays until another phase command
          s_nxt.phase  = s_r.sh[dsc_pkg::PHASE_BIT];
          s_nxt.dacreg = s_r.inreg;
        end
        dsc_pkg::CODE_LOAD_ALL:
        begin
          for (int i = 0; i < NCH; i++)
            s_nxt.dacreg[i] = data;
          s_nxt.power = dsc_pkg::POWER_RST;
        end
        dsc_pkg::CODE_LOAD_INPUT:
        begin
          for (int i = 0; i < NCH; i++)
            if (hot[i])
              s_nxt.inreg[i] = data;
        end
        dsc_pkg::CODE_LOAD_BOTH:
        begin
          for (int i = 0; i < NCH; i++)
            if (hot[i])
            begin
              s_nxt.inreg[i]  = data;
              s_nxt.dacreg[i] = data;
            end
          s_nxt.power = dsc_pkg::POWER_RST;
        end
        dsc_pkg::CODE_SW_LOAD:
        begin
          // All channels in one edge, address and data ignored
          s_nxt.dacreg = s_r.inreg;
        end
        default:
        begin
          s_nxt.code = code;
        end
      endcase
    end

    // Level transparency wins over any serial command
    if (!s_r.ld_sy[1])
      s_nxt.dacreg = s_nxt.inreg;

    for (int i = 0; i < NCH; i++)
      s_nxt.upd[i] = (s_nxt.dacreg[i] != s_r.dacreg[i]);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_r        <= '0;
      s_r.cs_sy  <= 2'h3;
      s_r.ld_sy  <= 2'h3;
      s_r.cs_d   <= 1'b1;
      s_r.phase  <= dsc_pkg::PHASE_RST;
      s_r.sdo    <= dsc_pkg::SDO_RST;
      s_r.power  <= dsc_pkg::POWER_RST;
      for (int i = 0; i < NCH; i++)
      begin
        s_r.inreg[i]  <= dsc_pkg::CODE_RST;
        s_r.dacreg[i] <= dsc_pkg::CODE_RST;
      end
    end
    else
      s_r <= s_nxt;
  end

  // Plain push-pull drive, never released
  assign bus.sdo          = s_r.sdo;
  assign dac_code_o       = s_r.dacreg;
  assign dac_update_o     = s_r.upd;
  assign buffer_on_o      = s_r.power;
  assign sdo_rising_o     = s_r.phase;
  assign command_code_o   = s_r.code;
  assign command_strobe_o = s_r.strobe;
  assign frame_short_o    = s_r.short_f;
endmodule

// file: rtl/dsc_fifo.sv
`timescale 1ns/1ps
module dsc_fifo #(
  parameter int W     = 17,
  parameter int DEPTH = 4
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic      [W-1:0] out_data_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);
  localparam logic [AW:0]   FULL_CNT = (AW + 1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
  } dsc_fifo_s;

  dsc_fifo_s s_r;
  dsc_fifo_s s_nxt;
  logic      push;
  logic      pop;

  assign in_ready_o  = (s_r.cnt != FULL_CNT);
  assign out_valid_o = (s_r.cnt != '0);
  assign out_data_o  = s_r.mem[s_r.rp];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always_comb
  begin
    s_nxt = s_r;
    if (push)
    begin
      s_nxt.mem[s_r.wp] = in_data_i;
      s_nxt.wp          = (s_r.wp == LAST_IDX) ? '0 : s_r.wp + 1'b1;
    end
    if (pop)
    begin
      s_nxt.rp = (s_r.rp == LAST_IDX) ? '0 : s_r.rp + 1'b1;
    end
    case ({push, pop})
      2'h2:    s_nxt.cnt = s_r.cnt + 1'b1;
      2'h1:    s_nxt.cnt = s_r.cnt - 1'b1;
      default: s_nxt.cnt = s_r.cnt;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end
endmodule

// file: rtl/dsc_host.sv
`timescale 1ns/1ps
module dsc_host #(
  parameter int HALF_CYC = dsc_pkg::SCLK_HALF_CYC,
  parameter int DEPTH    = dsc_pkg::FIFO_DEPTH
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  dsc_if.host              bus,
  input  wire logic [15:0] tx_word_i,
  input  wire logic        tx_last_i,
  input  wire logic        tx_valid_i,
  output logic             tx_ready_o,
  output logic      [15:0] rx_word_o,
  output logic             rx_valid_o,
  input  wire logic        dac_load_req_i,
  output logic             busy_o
);
  localparam logic [7:0] HALF_M1 = 8'(HALF_CYC - 1);

  typedef enum logic [2:0] {
    ST_LOAD,
    ST_LOW,
    ST_HIGH,
    ST_GAP,
    ST_HOLD
  } dsc_host_e;

  typedef struct packed {
    dsc_host_e   st;
    logic [7:0]  cnt;
    logic [3:0]  bitn;
    logic [15:0] sh;
    logic        last;
    logic        in_frame;
    logic [15:0] rx_sh;
    logic [15:0] rx_word;
    logic        rx_valid;
    logic        cs_n;
    logic        sclk;
    logic        sdi;
    logic        load_n;
    logic [1:0]  sdo_sy;
  } dsc_host_s;

  dsc_host_s   s_r;
  dsc_host_s   s_nxt;
  logic        f_valid;
  logic        f_ready;
  logic [16:0] f_data;
  logic        half_done;

  dsc_fifo #(
    .W     (17),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (tx_valid_i),
    .in_ready_o  (tx_ready_o),
    .in_data_i   ({tx_last_i, tx_word_i}),
    .out_valid_o (f_valid),
    .out_ready_i (f_ready),
    .out_data_o  (f_data)
  );

  assign f_ready   = (s_r.st == ST_LOAD);
  assign half_done = (s_r.cnt == HALF_M1);

  always_comb
  begin
    s_nxt        = s_r;
    s_nxt.sdo_sy = {s_r.sdo_sy[0], bus.sdo};
    s_nxt.load_n = ~dac_load_req_i;
    s_nxt.rx_valid = 1'b0;
    s_nxt.cnt    = half_done ? '0 : s_r.cnt + 1'b1;
    case (s_r.st)
      ST_LOAD:
      begin
        s_nxt.cnt = '0;
        if (f_valid)
        begin
          s_nxt.sh       = f_data[15:0];
          s_nxt.last     = f_data[16];
          s_nxt.sdi      = f_data[15];
          s_nxt.cs_n     = 1'b0;
          s_nxt.in_frame = 1'b1;
          s_nxt.bitn     = '0;
          s_nxt.st       = ST_LOW;
        end
      end
      ST_LOW:
      begin
        if (half_done)
        begin
          // Sample point of CPOL=0/CPHA=0
          s_nxt.sclk  = 1'b1;
          s_nxt.rx_sh = {s_r.rx_sh[14:0], s_r.sdo_sy[1]};
          s_nxt.st    = ST_HIGH;
        end
      end
      ST_HIGH:
      begin
        if (half_done)
        begin
          s_nxt.sclk = 1'b0;
          s_nxt.bitn = s_r.bitn + 1'b1;
          s_nxt.sh   = {s_r.sh[14:0], 1'b0};
          s_nxt.sdi  = s_r.sh[14];
          s_nxt.st   = ST_LOW;
          if (s_r.bitn == 4'hf)
          begin
            s_nxt.rx_word  = s_r.rx_sh;
            s_nxt.rx_valid = 1'b1;
            // Words go out in buffer order; farthest device first
            s_nxt.st       = s_r.last ? ST_GAP : ST_LOAD;
          end
        end
      end
      ST_GAP:
      begin
        if (half_done)
        begin
          // One edge executes every chained device
          s_nxt.cs_n = 1'b1;
          s_nxt.st   = ST_HOLD;
        end
      end
      ST_HOLD:
      begin
        if (half_done)
        begin
          s_nxt.in_frame = 1'b0;
          s_nxt.st       = ST_LOAD;
        end
      end
      default: s_nxt.st = ST_LOAD;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_r        <= '0;
      s_r.st     <= ST_LOAD;
      s_r.cs_n   <= 1'b1;
      s_r.load_n <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end

  // Clock only moves inside a frame, held low otherwise
  assign bus.sclk              = s_r.sclk;
  assign bus.cs_n              = s_r.cs_n;
  assign bus.sdi               = s_r.sdi;
  assign bus.dac_load_strobe_n = s_r.load_n;
  assign rx_word_o             = s_r.rx_word;
  assign rx_valid_o            = s_r.rx_valid;
  assign busy_o                = s_r.in_frame;
endmodule

// file: sim/dsc_chk_sva.sv
`timescale 1ns/1ps
module dsc_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic sdo,
  input wire logic sdo_rising_o,
  input wire logic command_strobe_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  property p_sdo_hold;
    cs_n && $past(cs_n) |-> $stable(sdo);
  endproperty
  a_sdo_hold: assert property (p_sdo_hold) else $error("sdo moved while deselected");

  // Lag after the clock edge bounded by sync stages, well inside one half period
  property p_sdo_fall;
    $changed(sdo) && !sdo_rising_o |-> !sclk && $past(sclk, 6);
  endproperty
  a_sdo_fall: assert property (p_sdo_fall) else $error("sdo not on falling edge");

  property p_sdo_rise;
    $changed(sdo) && sdo_rising_o |-> sclk && !$past(sclk, 6);
  endproperty
  a_sdo_rise: assert property (p_sdo_rise) else $error("sdo not on rising edge");

  property p_idle_low;
    cs_n |-> !sclk;
  endproperty
  a_idle_low: assert property (p_idle_low) else $error("sclk high while idle");

  property p_first_low;
    $fell(cs_n) |-> !sclk [*5];
  endproperty
  a_first_low: assert property (p_first_low) else $error("sclk rose too soon");

  property p_high_width;
    $rose(sclk) |-> sclk [*6] ##1 !sclk;
  endproperty
  a_high_width: assert property (p_high_width) else $error("sclk high width");

  property p_sdi_stable;
    $changed(sdi) |-> !sclk;
  endproperty
  a_sdi_stable: assert property (p_sdi_stable) else $error("sdi moved while sclk high");

  property p_exec;
    command_strobe_o |-> cs_n && $past(cs_n, 3) && !$past(cs_n, 6);
  endproperty
  a_exec: assert property (p_exec) else $error("command not tied to select rise");

  c_exec: cover property ($rose(command_strobe_o));
  c_sdo_fall: cover property ($changed(sdo) && !sdo_rising_o);
  c_sdo_rise: cover property ($changed(sdo) && sdo_rising_o);
endmodule

// file: sim/testbench.sv
`timescale 1ns/1ps
module testbench;
  typedef struct packed
  {
    logic [7:0][7:0] dac;
    logic [2:0]      code;
    logic            rise;
    logic [7:0]      pwr;
    logic [7:0]      upd;
  } dsc_exp_s;

  localparam int LAG = 17;
  logic            clk_i;
  logic            rst_i;
  logic [15:0]     tx_word_i;
  logic            tx_last_i;
  logic            tx_valid_i;
  logic            tx_ready_o;
  logic [15:0]     rx_word_o;
  logic            rx_valid_o;
  logic            dac_load_req_i;
  logic            busy_o;
  logic [7:0][7:0] dac_code_o;
  logic [7:0]      dac_update_o;
  logic [7:0]      buffer_on_o;
  logic            sdo_rising_o;
  logic [2:0]      command_code_o;
  logic            command_strobe_o;
  logic            frame_short_o;
  int              num_errors;
  int              samples_checked;
  logic [15:0]     rxq[$];
  dsc_exp_s        cmdq[$];
  logic            bits[$];
  logic [7:0][7:0] inp_m;
  logic [7:0][7:0] dac_m;
  logic            rise_m;
  logic [7:0]      pwr_m;
  dsc_exp_s        cmd_now;
  logic            full_seen;
  int unsigned     seed;

  dsc_if bus_if ();
  dsc_host dsc_host_inst (.clk_i(clk_i), .rst_i(rst_i), .bus(bus_if), .tx_word_i(tx_word_i),
    .tx_last_i(tx_last_i), .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o),
    .rx_word_o(rx_word_o), .rx_valid_o(rx_valid_o), .dac_load_req_i(dac_load_req_i),
    .busy_o(busy_o));
  dsc_dev dsc_dev_inst (.clk_i(clk_i), .rst_i(rst_i), .bus(bus_if), .dac_code_o(dac_code_o),
    .dac_update_o(dac_update_o), .buffer_on_o(buffer_on_o), .sdo_rising_o(sdo_rising_o),
    .command_code_o(command_code_o), .command_strobe_o(command_strobe_o),
    .frame_short_o(frame_short_o));
  dsc_chk dsc_chk_inst (.clk_i(clk_i), .rst_i(rst_i), .cs_n(bus_if.cs_n), .sclk(bus_if.sclk),
    .sdi(bus_if.sdi), .sdo(bus_if.sdo), .sdo_rising_o(sdo_rising_o),
    .command_strobe_o(command_strobe_o));

  assign cmd_now = {dac_code_o, command_code_o, sdo_rising_o, buffer_on_o, dac_update_o};

  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic results();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic fail(input string msg);
    num_errors++;
    $display("[FAIL] %0t %s", $time, msg);
  endtask

  task automatic tmo(input string msg);
    fail(msg);
    results();
  endtask

  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) fail($sformatf("rx word %h, expected %h", got, exp));
  endtask

  task automatic cmp_cmd(input dsc_exp_s got, input dsc_exp_s exp);
    samples_checked++;
    if (got !== exp) fail($sformatf("command result %h, expected %h", got, exp));
  endtask

  task automatic cmp_dac(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) fail($sformatf("dac codes %h, expected %h", got, exp));
  endtask

  // Device reference: only the last word of a frame executes
  task automatic model(input logic [15:0] w);
    logic [2:0]      ch;
    logic [7:0][7:0] old;
    logic [7:0]      upd;
    ch  = w[dsc_pkg::CHAN_MSB:dsc_pkg::CHAN_LSB];
    old = dac_m;
    case (w[dsc_pkg::CODE_MSB:dsc_pkg::CODE_LSB])
      dsc_pkg::CODE_CLEAR:
      begin
        inp_m = 64'h0;
        dac_m = 64'h0;
        pwr_m = dsc_pkg::POWER_RST;
      end
      dsc_pkg::CODE_SHUTDOWN: pwr_m = w[7:0];
      dsc_pkg::CODE_PHASE_LOAD:
      begin
        rise_m = w[dsc_pkg::PHASE_BIT];
        dac_m  = inp_m;
      end
      dsc_pkg::CODE_LOAD_ALL:
      begin
        dac_m = {8{w[7:0]}};
        pwr_m = dsc_pkg::POWER_RST;
      end
      dsc_pkg::CODE_LOAD_INPUT: inp_m[ch] = w[7:0];
      dsc_pkg::CODE_LOAD_BOTH:
      begin
        inp_m[ch] = w[7:0];
        dac_m[ch] = w[7:0];
        pwr_m     = dsc_pkg::POWER_RST;
      end
      dsc_pkg::CODE_SW_LOAD: dac_m = inp_m;
      default: ;
    endcase
    // Load pin low: DAC registers follow the inputs in the same edge
    if (dac_load_req_i) dac_m = inp_m;
    for (int i = 0; i < 8; i++)
      upd[i] = (dac_m[i] != old[i]);
    cmdq.push_back({dac_m, w[dsc_pkg::CODE_MSB:dsc_pkg::CODE_LSB], rise_m, pwr_m, upd});
  endtask

  // Called at a falling edge; leaves valid up so back-to-back words need no gap
  task automatic push(input logic [15:0] w, input logic last);
    int          n;
    int          base;
    logic [15:0] e;
    n          = 0;
    base       = bits.size();
    tx_word_i  = w;
    tx_last_i  = last;
    tx_valid_i = 1'b1;
    while (tx_ready_o !== 1'b1 && n < 2000)
    begin
      full_seen = 1'b1;
      @(negedge clk_i);
      n++;
    end
    if (n == 2000) tmo("push timeout");
    for (int i = 0; i < 16; i++)
      e[15-i] = (base + i >= LAG) ? bits[base+i-LAG] : 1'b0;
    for (int i = 15; i >= 0; i--)
      bits.push_back(w[i]);
    rxq.push_back(e);
    if (last) model(w);
    @(posedge clk_i);
    @(negedge clk_i);
  endtask

  task automatic idle();
    int n;
    n          = 0;
    tx_valid_i = 1'b0;
    repeat (3) @(negedge clk_i);
    // Busy drops for one cycle between queued frames; wait for every reply too
    while ((busy_o !== 1'b0 || rxq.size() != 0) && n < 20000)
    begin
      @(negedge clk_i);
      n++;
    end
    if (n == 20000) tmo("idle timeout");
    repeat (6) @(negedge clk_i);
  endtask

  function automatic logic [15:0] word(input logic [2:0] code);
    return {2'b00, 3'($urandom), code, 8'($urandom)};
  endfunction

  always @(negedge clk_i)
  begin
    if (rx_valid_o === 1'b1)
    begin
      if (rxq.size() == 0) fail("unexpected rx word");
      else cmp16(rx_word_o, rxq.pop_front());
    end
    if (command_strobe_o === 1'b1)
    begin
      if (cmdq.size() == 0) fail("unexpected command");
      else cmp_cmd(cmd_now, cmdq.pop_front());
    end
    if (frame_short_o !== 1'b0) fail("whole frame flagged as short");
  end

  initial
  begin
    num_errors      = 0;
    samples_checked = 0;
    rst_i           = 1'b1;
    tx_word_i       = 16'h0000;
    tx_last_i       = 1'b0;
    tx_valid_i      = 1'b0;
    dac_load_req_i  = 1'b0;
    inp_m           = 64'h0;
    dac_m           = 64'h0;
    rise_m          = dsc_pkg::PHASE_RST;
    pwr_m           = dsc_pkg::POWER_RST;
    full_seen       = 1'b0;
    seed            = $urandom(72960);
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
    rst_i = 1'b0;
    repeat (4) @(negedge clk_i);
    cmp_cmd(cmd_now, {64'h0, 3'h0, dsc_pkg::PHASE_RST, dsc_pkg::POWER_RST, 8'h00});
    for (int c = 0; c < 8; c++)
    begin
      push(word(3'(c)), 1'b1);
      idle();
    end
    // Queue more frames than the buffer holds
    for (int ch = 0; ch < 8; ch++)
      push({2'b00, 3'(ch), dsc_pkg::CODE_LOAD_INPUT, 8'($urandom)}, 1'b1);
    push(word(dsc_pkg::CODE_NOP), 1'b1);
    push(word(dsc_pkg::CODE_SW_LOAD), 1'b1);
    idle();
    cmp_dac(64'(full_seen), 64'h1);
    // Top channel bit set: rising-edge output mode
    push({2'b00, 3'h4, dsc_pkg::CODE_PHASE_LOAD, 8'h00}, 1'b1);
    for (int k = 0; k < 4; k++)
      push(word(k[0] ? dsc_pkg::CODE_LOAD_BOTH : dsc_pkg::CODE_NOP), 1'b1);
    push({2'b00, 3'h0, dsc_pkg::CODE_PHASE_LOAD, 8'h00}, 1'b1);
    idle();
    // Three-word frames: only the final word acts
    for (int k = 0; k < 6; k++)
    begin
      push(word(dsc_pkg::CODE_LOAD_ALL), 1'b0);
      push(word(3'($urandom)), 1'b0);
      push(word(3'($urandom)), 1'b1);
      idle();
    end
    dac_load_req_i = 1'b1;
    repeat (8) @(negedge clk_i);
    dac_m = inp_m;
    cmp_dac(dac_code_o, dac_m);
    push({2'b00, 3'h3, dsc_pkg::CODE_LOAD_INPUT, 8'($urandom)}, 1'b1);
    idle();
    dac_m = inp_m;
    cmp_dac(dac_code_o, dac_m);
    dac_load_req_i = 1'b0;
    repeat (8) @(negedge clk_i);
    if (rxq.size() != 0 || cmdq.size() != 0) fail("results missing");
    results();
  end
endmodule
